/* common/tpus_consts.vh */
// Constants for the two-point user scaling block
`ifndef TPUS_CONSTS_VH
`define TPUS_CONSTS_VH

// ==================================================================
// Register indices (byte address is four times the index)
`define TPUS_IDX_RES_CH1 14'd2
`define TPUS_IDX_RES_CH2 14'd3
`define TPUS_IDX_CH_BASE 14'd1000
`define TPUS_IDX_CH_STEP 14'd100
`define TPUS_NN_CMD 7'd1
`define TPUS_NN_AVG 7'd6
`define TPUS_NN_SENS 7'd11
`define TPUS_NN_GAIN 7'd17
`define TPUS_NN_DMIN 7'd24
`define TPUS_NN_PMIN 7'd25
`define TPUS_NN_DMAX 7'd26
`define TPUS_NN_PMAX 7'd27
`define TPUS_NN_CTRL 7'd30

// ==================================================================
// Commands and reset values
`define TPUS_CMD_CAP_MIN 32'd210
`define TPUS_CMD_CAP_MAX 32'd220
`define TPUS_RST_DMIN 16'h8000
`define TPUS_RST_DMAX 16'h7FFF
`define TPUS_RST_PMIN 32'hFFFF8000
`define TPUS_RST_PMAX 32'h00007FFF
`define TPUS_RST_SENS 32'd3500
`define TPUS_RST_AVG_LOG 3'd0
`define TPUS_RST_EN 1'b1
`define TPUS_AVG_LOG_MAX 3'd7

// ==================================================================
// Amplifier model: realisable gain is GAIN_NUM divided by an integer
`define TPUS_GAIN_NUM 48'd575
`define TPUS_GAIN_NUM_MILLI 32'd575000
`define TPUS_UV_PER_V 48'd1000000
`define TPUS_UV_HALF 48'd500000
`define TPUS_GAIN_DIV_MIN 8'd1
`define TPUS_GAIN_DIV_MAX 8'd255

`endif

/* design/tpus_scaler.v */
// Two-channel averaging, two-point user scaling and gain derivation
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tpus_consts.vh"

module tpus_scaler (
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [15:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire [15:0] ch0_sample_i,
    input wire ch0_sample_valid_i,
    input wire [15:0] ch1_sample_i,
    input wire ch1_sample_valid_i,
    output reg [7:0] ch0_gain_div_o,
    output reg [7:0] ch1_gain_div_o
);

    // ==================================================================
    // Arithmetic helpers
    // Scaled value of one reading; zero divisor gives plain offset
    function [31:0] tpus_scale;
        input [15:0] x;
        input [31:0] mul;
        input [31:0] dv;
        input [31:0] off;
        reg signed [63:0] prod;
        reg signed [31:0] quo;
        begin
            prod = $signed({{16{x[15]}}, x}) * $signed(mul);
            quo = 32'sh00000000;
            if (dv != 32'h00000000) begin
                quo = $signed(prod[31:0]) / $signed(dv);
            end
            tpus_scale = quo + off;
        end
    endfunction

    // Nearest integer divider for the amplifier, clamped to its range
    function [7:0] tpus_gain_div;
        input [31:0] sens;
        reg [47:0] t;
        begin
            t = ({16'h0000, sens} * `TPUS_GAIN_NUM + `TPUS_UV_HALF) / `TPUS_UV_PER_V;
            if (t < {40'h0000000000, `TPUS_GAIN_DIV_MIN}) begin
                tpus_gain_div = `TPUS_GAIN_DIV_MIN;
            end else if (t > {40'h0000000000, `TPUS_GAIN_DIV_MAX}) begin
                tpus_gain_div = `TPUS_GAIN_DIV_MAX;
            end else begin
                tpus_gain_div = t[7:0];
            end
        end
    endfunction

    // ==================================================================
    // Reset release through two flops
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // ==================================================================
    // APB decode
    wire [13:0] idx;
    wire acc;
    wire wr_acc;
    wire [1:0] ch_hit;
    wire [6:0] nn [0:1];
    wire [31:0] ch_rdata [0:1];
    wire [1:0] ch_ok;
    wire [31:0] res_q [0:1];
    reg [31:0] prdata_next;
    reg pslverr_next;
    assign idx = paddr_i[15:2];
    // Access phase, first cycle only; pready follows one edge later
    assign acc = psel_i && penable_i && !pready_o;
    assign wr_acc = acc && pwrite_i;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            localparam [13:0] BASE = (g == 0) ? `TPUS_IDX_CH_BASE
                : `TPUS_IDX_CH_BASE + `TPUS_IDX_CH_STEP;
            wire [13:0] rel;
            wire [15:0] smp;
            wire smp_vld;
            reg [15:0] dmin_reg;
            reg [15:0] dmax_reg;
            reg [31:0] pmin_reg;
            reg [31:0] pmax_reg;
            reg [31:0] sens_reg;
            reg [31:0] cmd_reg;
            reg [2:0] avg_log_reg;
            reg en_reg;
            reg [31:0] mul_reg;
            reg [31:0] div_reg;
            reg [31:0] off_reg;
            reg [7:0] gdiv_reg;
            reg [31:0] gmilli_reg;
            reg signed [23:0] sum_reg;
            reg [7:0] fill_reg;
            reg [6:0] wptr_reg;
            reg [15:0] hist [0:127];
            reg [15:0] avg_reg;
            reg avg_vld_reg;
            reg [31:0] res_reg;
            wire [7:0] n_avg;
            wire [6:0] old_ptr;
            wire signed [23:0] sum_next;
            wire [7:0] fill_next;
            wire signed [23:0] avg_shift;
            wire [31:0] mul_next;
            wire [31:0] div_next;
            wire [31:0] off_next;
            wire wr_ch;
            assign rel = idx - BASE;
            assign nn[g] = rel[6:0];
            assign wr_ch = wr_acc && ch_hit[g];
            assign smp = (g == 0) ? ch0_sample_i : ch1_sample_i;
            assign smp_vld = (g == 0) ? ch0_sample_valid_i : ch1_sample_valid_i;
            // ----------------------------------------------------------
            // Host configuration registers and capture commands
            always @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    dmin_reg <= `TPUS_RST_DMIN;
                    dmax_reg <= `TPUS_RST_DMAX;
                    pmin_reg <= `TPUS_RST_PMIN;
                    pmax_reg <= `TPUS_RST_PMAX;
                    sens_reg <= `TPUS_RST_SENS;
                    cmd_reg <= 32'h00000000;
                    avg_log_reg <= `TPUS_RST_AVG_LOG;
                    en_reg <= `TPUS_RST_EN;
                end else if (wr_ch) begin
                    case (nn[g])
                        `TPUS_NN_CMD: begin
                            cmd_reg <= pwdata_i;
                            if (pwdata_i == `TPUS_CMD_CAP_MIN) begin
                                dmin_reg <= avg_reg;
                            end
                            if (pwdata_i == `TPUS_CMD_CAP_MAX) begin
                                dmax_reg <= avg_reg;
                            end
                        end
                        `TPUS_NN_PMIN: pmin_reg <= pwdata_i;
                        `TPUS_NN_PMAX: pmax_reg <= pwdata_i;
                        `TPUS_NN_SENS: sens_reg <= pwdata_i;
                        `TPUS_NN_CTRL: en_reg <= pwdata_i[0];
                        `TPUS_NN_AVG: begin
                            // Only powers of two up to 128 are accepted
                            if (pwdata_i[31:8] == 24'h000000 && pwdata_i[7:0] != 8'h00
                                && (pwdata_i[7:0] & (pwdata_i[7:0] - 8'h01)) == 8'h00) begin
                                avg_log_reg <= {|(pwdata_i[7:0] & 8'hF0), |(pwdata_i[7:0] & 8'hCC),
                                    |(pwdata_i[7:0] & 8'hAA)};
                            end
                        end
                        default: ;
                    endcase
                end
            end

            // ----------------------------------------------------------
            // Moving average over the last 2^k readings
            assign n_avg = 8'h01 << avg_log_reg;
            assign old_ptr = wptr_reg - n_avg[6:0];
            assign fill_next = (fill_reg < n_avg) ? fill_reg + 8'h01 : fill_reg;
            assign sum_next = (fill_reg < n_avg)
                ? sum_reg + {{8{smp[15]}}, smp}
                : sum_reg + {{8{smp[15]}}, smp} - {{8{hist[old_ptr][15]}}, hist[old_ptr]};
            assign avg_shift = sum_next >>> avg_log_reg;

            // History memory has no reset; fill count masks stale words
            always @(posedge ref_clk_i) begin
                if (smp_vld) begin
                    hist[wptr_reg] <= smp;
                end
            end

            always @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    sum_reg <= 24'sh000000;
                    fill_reg <= 8'h00;
                    wptr_reg <= 7'h00;
                    avg_reg <= 16'h0000;
                    avg_vld_reg <= 1'b0;
                end else if (wr_ch && nn[g] == `TPUS_NN_AVG) begin
                    // Any write to the window length register, accepted or not, restarts the average from empty
                    sum_reg <= 24'sh000000;
                    fill_reg <= 8'h00;
                    avg_vld_reg <= 1'b0;
                end else begin
                    avg_vld_reg <= 1'b0;
                    if (smp_vld) begin
                        sum_reg <= sum_next;
                        fill_reg <= fill_next;
                        wptr_reg <= wptr_reg + 7'h01;
                        if (fill_next == n_avg) begin
                            avg_reg <= avg_shift[15:0];
                            avg_vld_reg <= 1'b1;
                        end
                    end
                end
            end

            // ----------------------------------------------------------
            // Coefficients from the two point pairs
            // two pairs
            assign mul_next = pmax_reg - pmin_reg;
            assign div_next = {{16{dmax_reg[15]}}, dmax_reg} - {{16{dmin_reg[15]}}, dmin_reg};
            assign off_next = pmin_reg - tpus_scale(dmin_reg, mul_next, div_next, 32'h00000000);

            always @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    mul_reg <= 32'h00000000;
                    div_reg <= 32'h00000000;
                    off_reg <= 32'h00000000;
                    gdiv_reg <= `TPUS_GAIN_DIV_MIN;
                    gmilli_reg <= 32'h00000000;
                end else begin
                    mul_reg <= mul_next;
                    div_reg <= div_next;
                    off_reg <= off_next;
                    gdiv_reg <= tpus_gain_div(sens_reg);
                    gmilli_reg <= `TPUS_GAIN_NUM_MILLI / {24'h000000, gdiv_reg};
                end
            end
            // ----------------------------------------------------------
            // Result update on each new averaged reading, except with scaling enabled and a zero divisor
            always @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    res_reg <= 32'h00000000;
                end else if (avg_vld_reg) begin
                    if (!en_reg) begin
                        res_reg <= {{16{avg_reg[15]}}, avg_reg};
                    end else if (div_reg != 32'h00000000) begin
                        res_reg <= tpus_scale(avg_reg, mul_reg, div_reg, off_reg);
                    end
                end
            end
            assign res_q[g] = res_reg;

            // ----------------------------------------------------------
            // Per-channel read mux
            assign ch_ok[g] = (nn[g] == `TPUS_NN_CMD) || (nn[g] == `TPUS_NN_AVG)
                || (nn[g] == `TPUS_NN_SENS) || (nn[g] == `TPUS_NN_GAIN)
                || (nn[g] == `TPUS_NN_DMIN) || (nn[g] == `TPUS_NN_PMIN)
                || (nn[g] == `TPUS_NN_DMAX) || (nn[g] == `TPUS_NN_PMAX)
                || (nn[g] == `TPUS_NN_CTRL);
            assign ch_rdata[g] =
                (nn[g] == `TPUS_NN_CMD) ? cmd_reg :
                (nn[g] == `TPUS_NN_AVG) ? {24'h000000, n_avg} :
                (nn[g] == `TPUS_NN_SENS) ? sens_reg :
                (nn[g] == `TPUS_NN_GAIN) ? gmilli_reg :
                (nn[g] == `TPUS_NN_DMIN) ? {{16{dmin_reg[15]}}, dmin_reg} :
                (nn[g] == `TPUS_NN_PMIN) ? pmin_reg :
                (nn[g] == `TPUS_NN_DMAX) ? {{16{dmax_reg[15]}}, dmax_reg} :
                (nn[g] == `TPUS_NN_PMAX) ? pmax_reg :
                (nn[g] == `TPUS_NN_CTRL) ? {31'h00000000, en_reg} : 32'h00000000;
        end
    endgenerate

    // Channel windows of one hundred indices each
    assign ch_hit[0] = (idx >= `TPUS_IDX_CH_BASE)
        && (idx < `TPUS_IDX_CH_BASE + `TPUS_IDX_CH_STEP);
    assign ch_hit[1] = (idx >= `TPUS_IDX_CH_BASE + `TPUS_IDX_CH_STEP)
        && (idx < `TPUS_IDX_CH_BASE + `TPUS_IDX_CH_STEP + `TPUS_IDX_CH_STEP);

    // ==================================================================
    // Read data and error selection
    always @* begin
        prdata_next = 32'h00000000;
        pslverr_next = 1'b0;
        if (idx == `TPUS_IDX_RES_CH1) begin
            prdata_next = res_q[0];
        end else if (idx == `TPUS_IDX_RES_CH2) begin
            prdata_next = res_q[1];
        end else if (ch_hit[0] && ch_ok[0]) begin
            prdata_next = ch_rdata[0];
        end else if (ch_hit[1] && ch_ok[1]) begin
            prdata_next = ch_rdata[1];
        end else begin
            pslverr_next = 1'b1; // Unmapped index
        end
    end
    // Answer one edge after the access phase opens
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= acc;
            pslverr_o <= acc && pslverr_next;
            if (acc && !pwrite_i) begin
                prdata_o <= prdata_next;
            end
        end
    end
    // Divider codes to the amplifier, straight from flops
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ch0_gain_div_o <= `TPUS_GAIN_DIV_MIN;
            ch1_gain_div_o <= `TPUS_GAIN_DIV_MIN;
        end else begin
            ch0_gain_div_o <= g_ch[0].gdiv_reg;
            ch1_gain_div_o <= g_ch[1].gdiv_reg;
        end
    end

endmodule // tpus_scaler
`default_nettype wire

/* sim/tpus_scaler_chk.sv */
// Assertion checker for the two-point user scaling block
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Checker on the top module ports
module tpus_scaler_chk (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [15:0] ch0_sample_i,
    input wire logic ch0_sample_valid_i,
    input wire logic [15:0] ch1_sample_i,
    input wire logic ch1_sample_valid_i,
    input wire logic [7:0] ch0_gain_div_o,
    input wire logic [7:0] ch1_gain_div_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Bus answer timing and shape
    property p_ready_after_take;
        psel_i && penable_i && !pready_o |=> pready_o;
    endproperty
    a_ready_after_take: assert property (p_ready_after_take) else $error("late answer");
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_ready_cause;
        pready_o |-> psel_i && penable_i;
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
    property p_err_with_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
    property p_err_read_zero;
        pslverr_o && !pwrite_i |-> prdata_o == 32'h00000000;
    endproperty
    a_err_read_zero: assert property (p_err_read_zero) else $error("error read data");
    // Read data only moves on an answer edge
    property p_rdata_hold;
        !pready_o |-> $stable(prdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    // Gain codes stay within the divider range
    property p_gain_nonzero;
        ch0_gain_div_o != 8'h00 && ch1_gain_div_o != 8'h00;
    endproperty
    a_gain_nonzero: assert property (p_gain_nonzero) else $error("gain code zero");
    // Reset sensitivity gives divider code two shortly after release
    property p_gain_reset;
        $rose(arst_n_i) |-> ##[1:6] (ch0_gain_div_o == 8'h02 && ch1_gain_div_o == 8'h02);
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("reset gain code");

    // Main scenarios seen
    c_write: cover property (pready_o && pwrite_i);
    c_read: cover property (pready_o && !pwrite_i);
    c_err: cover property (pslverr_o);
endmodule // tpus_scaler_chk

bind tpus_scaler tpus_scaler_chk i_tpus_scaler_chk (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ch0_sample_i(ch0_sample_i),
    .ch0_sample_valid_i(ch0_sample_valid_i), .ch1_sample_i(ch1_sample_i),
    .ch1_sample_valid_i(ch1_sample_valid_i), .ch0_gain_div_o(ch0_gain_div_o),
    .ch1_gain_div_o(ch1_gain_div_o));
`default_nettype wire

/* sim/tpus_scaler_tb.sv */
// Self-checking testbench for the two-point user scaling block
`timescale 1ns/1ps
`default_nettype none
`include "tpus_consts.vh"
// ==================================================================
// Bench top
module tpus_scaler_tb;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [15:0] paddr_i = 16'h0000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [15:0] ch0_sample_i = 16'h0000;
    logic ch0_sample_valid_i = 1'b0;
    logic [15:0] ch1_sample_i = 16'h0000;
    logic ch1_sample_valid_i = 1'b0;
    wire [31:0] prdata_o;
    wire pready_o;
    wire pslverr_o;
    wire [7:0] ch0_gain_div_o;
    wire [7:0] ch1_gain_div_o;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] rdat;
    logic rerr;

    // 10 MHz clock
    always #50 ref_clk_i = ~ref_clk_i;

    tpus_scaler i_tpus_scaler (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ch0_sample_i(ch0_sample_i), .ch0_sample_valid_i(ch0_sample_valid_i),
        .ch1_sample_i(ch1_sample_i), .ch1_sample_valid_i(ch1_sample_valid_i),
        .ch0_gain_div_o(ch0_gain_div_o), .ch1_gain_div_o(ch1_gain_div_o));

    // ==================================================================
    // Helpers
    task automatic complete_run();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    // One bus transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
        int n = 0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            $display("unexpected at %0t: bus answer timeout", $time);
        end
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [13:0] idx, input logic [31:0] exp, input string m);
        apb(1'b0, idx, 32'h00000000);
        chk_word(rdat, exp, m);
    endtask

    // One-cycle reading pulse, then time for the result to land
    task automatic samp(input int ch, input logic [15:0] val);
        @(posedge ref_clk_i);
        if (ch == 0) begin
            ch0_sample_i <= val;
            ch0_sample_valid_i <= 1'b1;
        end else begin
            ch1_sample_i <= val;
            ch1_sample_valid_i <= 1'b1;
        end
        @(posedge ref_clk_i);
        ch0_sample_valid_i <= 1'b0;
        ch1_sample_valid_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask

    function automatic logic [13:0] cidx(input int y, input logic [6:0] nn);
        cidx = 14'(`TPUS_IDX_CH_BASE + `TPUS_IDX_CH_STEP * y + nn);
    endfunction

    // Expected two-point result, truncating division
    function automatic logic [31:0] scale(input int x, dl, dh, pl, ph);
        int m;
        int d;
        m = ph - pl;
        d = dh - dl;
        scale = 32'((x * m) / d + pl - (dl * m) / d);
    endfunction

    // ==================================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rd(cidx(0, `TPUS_NN_DMIN), 32'hFFFF8000, "min digital");
        rd(cidx(1, `TPUS_NN_DMAX), 32'h00007FFF, "max digital");
        rd(cidx(0, `TPUS_NN_CTRL), 32'h00000001, "enable");
        rd(cidx(1, `TPUS_NN_SENS), 32'h00000DAC, "sensitivity");
        rd(cidx(0, `TPUS_NN_GAIN), 32'h0004630C, "gain readback");
        chk_code(ch0_gain_div_o, 8'h02, "gain code");
        apb(1'b0, 14'h0005, 32'h00000000);
        chk_word({31'h0, rerr}, 32'h00000001, "unmapped error");
        wr(cidx(0, `TPUS_NN_GAIN), 32'h00000001);
        rd(cidx(0, `TPUS_NN_GAIN), 32'h0004630C, "gain read only");
        $display("test reset done");
        samp(0, 16'hFF9C);
        samp(1, 16'h04D2);
        rd(`TPUS_IDX_RES_CH1, 32'hFFFFFF9C, "identity one");
        rd(`TPUS_IDX_RES_CH2, 32'h000004D2, "identity two");
        $display("test identity done");
        wr(cidx(0, `TPUS_NN_PMIN), 32'h00000000);
        samp(0, 16'hFC18);
        wr(cidx(0, `TPUS_NN_CMD), `TPUS_CMD_CAP_MIN);
        wr(cidx(0, `TPUS_NN_PMAX), 32'h00002710);
        samp(0, 16'h0BB8);
        wr(cidx(0, `TPUS_NN_CMD), `TPUS_CMD_CAP_MAX);
        rd(cidx(0, `TPUS_NN_DMIN), 32'hFFFFFC18, "captured min");
        rd(cidx(0, `TPUS_NN_DMAX), 32'h00000BB8, "captured max");
        samp(0, 16'h03E8);
        rd(`TPUS_IDX_RES_CH1, scale(1000, -1000, 3000, 0, 10000), "scaled");
        samp(0, 16'hF449);
        rd(`TPUS_IDX_RES_CH1, scale(-2999, -1000, 3000, 0, 10000), "scaled neg");
        rd(`TPUS_IDX_RES_CH2, 32'h000004D2, "other channel");
        rd(cidx(0, `TPUS_NN_PMAX), 32'h00002710, "max physical");
        wr(cidx(0, `TPUS_NN_CTRL), 32'h00000000);
        samp(0, 16'h03E8);
        rd(`TPUS_IDX_RES_CH1, 32'h000003E8, "scaling off");
        $display("test calibration done");
        wr(cidx(0, `TPUS_NN_AVG), 32'h00000002);
        rd(cidx(0, `TPUS_NN_AVG), 32'h00000002, "window length");
        samp(0, 16'h07D0);
        rd(`TPUS_IDX_RES_CH1, 32'h000003E8, "window filling");
        samp(0, 16'h0BB8);
        rd(`TPUS_IDX_RES_CH1, 32'h000009C4, "average of two");
        $display("test averaging done");
        samp(1, 16'h01F4);
        wr(cidx(1, `TPUS_NN_CMD), `TPUS_CMD_CAP_MIN);
        wr(cidx(1, `TPUS_NN_CMD), `TPUS_CMD_CAP_MAX);
        rd(cidx(1, `TPUS_NN_CMD), `TPUS_CMD_CAP_MAX, "last command");
        samp(1, 16'h02BC);
        rd(`TPUS_IDX_RES_CH2, 32'h000001F4, "zero divisor hold");
        $display("test zero divisor done");
        wr(cidx(1, `TPUS_NN_SENS), 32'h00001450);
        for (int i = 0; i < 16 && ch1_gain_div_o !== 8'h03; i++) begin
            @(posedge ref_clk_i);
        end
        chk_code(ch1_gain_div_o, 8'h03, "derived code");
        rd(cidx(1, `TPUS_NN_GAIN), 32'h0002ECB2, "derived readback");
        $display("test gain done");
        complete_run();
    end

    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        #1000000;
        miscompares++;
        $display("unexpected at %0t: run timed out", $time);
        complete_run();
    end
endmodule // tpus_scaler_tb
`default_nettype wire
